// ### bench/dtc_pin_model.sv
/*
 * Far-side model of one external count pin, idle high.
 * Assumes pulse is called just after a rising pclk edge.
 */
`default_nettype none
module dtc_pin_model (
   input  wire logic pclk,
   output var  logic count_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial count_pin = 1'h1;
   // Each level held w >= 2 clocks
   task automatic pulse(input int n, input int w);
      repeat (n) begin
         count_pin <= 1'h0;
         repeat (w) @(posedge pclk);
         count_pin <= 1'h1;
         repeat (w) @(posedge pclk);
      end
   endtask
endmodule
`default_nettype wire

// ### bench/tb_dual_timer_counter_modes.sv
/*
 * Self-checking bench of the dual timer/counter in counter mode and split timer mode.
 * Assumes dtc_top on APB and two pin models on the count pins.
 */
`default_nettype none
module tb_dual_timer_counter_modes;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic        pready, pslverr, err, a_pin, b_pin, a_flag, b_flag;
   logic        a_gate = 0, b_gate = 0, a_ack = 0, b_ack = 0;
   int          bad_count = 0, checks = 0, seed = 32'hfdf3a737, r, t, m;
   int          cyc = 0, hit;
   always #10 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;
   dtc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_a_count_pin(a_pin), .timer_b_count_pin(b_pin),
      .timer_a_gate_pin(a_gate), .timer_b_gate_pin(b_gate),
      .timer_a_irq_ack(a_ack), .timer_b_irq_ack(b_ack),
      .timer_a_overflow_flag(a_flag), .timer_b_overflow_flag(b_flag));
   dtc_pin_model pin_a (.pclk(pclk), .count_pin(a_pin));
   dtc_pin_model pin_b (.pclk(pclk), .count_pin(b_pin));
   task automatic give_verdict;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] idx,
                      input logic [7:0] wd);
      int k;
      k = 0;
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'h1 && k < 8);
      if (pready !== 1'h1) begin
         bad_count++;
         give_verdict();
      end else begin
         rd = prdata;
         err = pslverr;
         hit = cyc;
         psel <= 1'h0;
         penable <= 1'h0;
         @(posedge pclk);
      end
   endtask
   // Load, count n pin pulses, stop, compare with integer model
   task automatic trial(input int t, input logic [3:0] nib,
                        input logic [7:0] s, input int n, input bit open);
      logic [7:0] el, eh;
      int         v, f, i;
      el = (nib[1:0] == 2'h0) ? (s | 8'h1C) : (s | 8'hFC);
      eh = (nib[1:0] == 2'h2) ? el : 8'hFF;
      f = 0;
      apb(1'h1, dtc_pkg::IDX_MODE, (t == 0) ? {4'h0, nib} : {nib, 4'h0});
      apb(1'h1, dtc_pkg::IDX_A_LOW + t[7:0], el);
      apb(1'h1, dtc_pkg::IDX_A_HIGH + t[7:0], eh);
      apb(1'h1, dtc_pkg::IDX_CTRL, (t == 0) ? 8'h10 : 8'h40);
      if (t == 0)
         pin_a.pulse(n, 2 + n % 2);
      else
         pin_b.pulse(n, 2 + n % 2);
      repeat (6) @(posedge pclk);
      apb(1'h1, dtc_pkg::IDX_CTRL, 8'hA0);
      for (i = 0; i < n * open; i++) begin
         case (nib[1:0])
            2'h0: begin
               v = {eh, el[4:0]} + 1;
               f |= v >> 13;
               el[4:0] = v[4:0];
               eh = v[12:5];
            end
            2'h1: begin
               v = {eh, el} + 1;
               f |= v >> 16;
               {eh, el} = v[15:0];
            end
            default: if (t == 0 || nib[1:0] == 2'h2) begin
               f |= (el == 8'hFF);
               el = (el == 8'hFF && nib[1] && !nib[0]) ? eh : el + 8'h01;
            end
         endcase
      end
      apb(1'h0, dtc_pkg::IDX_A_LOW + t[7:0], 8'h00);
      check(rd, {24'h0, el});
      apb(1'h0, dtc_pkg::IDX_A_HIGH + t[7:0], 8'h00);
      check(rd, {24'h0, eh});
      check({31'h0, (t == 0) ? a_flag : b_flag}, f);
      a_ack <= (t == 0);
      b_ack <= (t == 1);
      @(posedge pclk);
      a_ack <= 1'h0;
      b_ack <= 1'h0;
      repeat (2) @(posedge pclk);
      check({31'h0, a_flag | b_flag}, 32'h0);
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      apb(1'h0, dtc_pkg::IDX_MODE, 8'h00);
      check(rd, 32'h0);
      apb(1'h0, 8'h90, 8'h00);
      check({31'h0, err}, 32'h1);
      for (t = 0; t < 2; t++) begin
         for (m = 0; m < 4; m++) begin
            r = $random(seed);
            trial(t, {2'h1, m[1:0]}, r[7:0], r[9:8] + 1, 1'h1);
         end
      end
      trial(0, 4'hD, 8'h00, 3, 1'h0);
      a_gate <= 1'h1;
      trial(0, 4'hD, 8'h00, 2, 1'h1);
      // Split timer mode at one clock per tick, both halves running
      apb(1'h1, dtc_pkg::IDX_HISPEED, 8'h08);
      apb(1'h1, dtc_pkg::IDX_MODE, 8'h03);
      r = $random(seed);
      apb(1'h1, dtc_pkg::IDX_A_LOW, r[7:0] | 8'hF0);
      apb(1'h1, dtc_pkg::IDX_A_HIGH, r[15:8] | 8'hF0);
      apb(1'h1, dtc_pkg::IDX_CTRL, 8'h50);
      m = hit;
      repeat (20 + r[19:16]) @(posedge pclk);
      apb(1'h1, dtc_pkg::IDX_CTRL, 8'hA0);
      m = hit - m;
      t = (r[7:0] | 8'hF0) + m;
      apb(1'h0, dtc_pkg::IDX_A_LOW, 8'h00);
      check(rd, t % 256);
      check({31'h0, a_flag}, t / 256);
      t = (r[15:8] | 8'hF0) + m;
      apb(1'h0, dtc_pkg::IDX_A_HIGH, 8'h00);
      check(rd, t % 256);
      check({31'h0, b_flag}, t / 256);
      apb(1'h1, dtc_pkg::IDX_CTRL, 8'h00);
      check({31'h0, a_flag | b_flag}, 32'h0);
      give_verdict();
   end
endmodule
`default_nettype wire

// ### hw/dtc_pkg.sv
/*
 * Constants, register map and carrier types of the dual timer/counter.
 * Assumes one 50 MHz APB clock, count and gate pins synchronous to it.
 */
// Overview of operation
// - Mode field 00b makes the timer a 13-bit timer/counter.
// - 13-bit mode: five low-byte bits carry straight into high-byte bit 0.
// - 13-bit mode: low-byte bits 7..5 are not counted, content undefined.
// - Timer advances only when run set and gate off or gate pin high.
// - Counter select 0 counts clock ticks, 1 counts count-pin falling edges.
// - 13-bit count wraps 1FFFh to 0000h and sets the overflow flag.
// - Timer tick comes from system divider, div-by-4 and div-by-1 selects.
// - Div-by-4 selects at prescale bits 3,4; div-by-1 at high-speed bits 3,4.
// - Timer B mirrors A: run bit 6, flag bit 7, select 6, gate 7.
// - Timer A mode in mode bits 1..0, timer B mode in bits 5..4.
// - Mode 01b counts all 16 bits, rolls over after FFFFh, sets flag.
// - Mode 10b counts low byte, reloads it from high byte after FFh.
// - Reload mode never changes the high byte; only software does.
// - Split mode: timer A low byte is normal 8-bit timer/counter.
// - Split mode: A high byte counts ticks, B run bit and B flag.
// - Timer B set to split mode stops and holds its value.
// - A split: timer B counts ticks only, no flag, no interrupt.
// - Count pin edge needs two high samples then two low samples.
// - Tick is 12, 4 or 1 clocks per timer, times 4 or 1024 at divider codes 2, 3; changeable while running.
`default_nettype none
package dtc_pkg;
   localparam int ADDR_W = 12;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRL     = 8'h88;
   localparam logic [7:0] IDX_MODE     = 8'h89;
   localparam logic [7:0] IDX_A_LOW    = 8'h8A;
   localparam logic [7:0] IDX_B_LOW    = 8'h8B;
   localparam logic [7:0] IDX_A_HIGH   = 8'h8C;
   localparam logic [7:0] IDX_B_HIGH   = 8'h8D;
   localparam logic [7:0] IDX_PRESCALE = 8'h8E;
   localparam logic [7:0] IDX_HISPEED  = 8'h96;
   localparam logic [7:0] IDX_PMDIV    = 8'h97;
   // Control flag bit positions
   localparam int BIT_A_RUN  = 4;
   localparam int BIT_A_FLAG = 5;
   localparam int BIT_B_RUN  = 6;
   localparam int BIT_B_FLAG = 7;
   // Mode register nibbles
   localparam int NIB_A_LSB = 0;
   localparam int NIB_B_LSB = 4;
   // Clock select bit positions
   localparam int BIT_A_SEL = 3;
   localparam int BIT_B_SEL = 4;
   localparam int BIT_PMD_LSB = 6;
   // Mode field encodings
   localparam logic [1:0] MODE_13BIT  = 2'h0;
   localparam logic [1:0] MODE_16BIT  = 2'h1;
   localparam logic [1:0] MODE_RELOAD = 2'h2;
   localparam logic [1:0] MODE_SPLIT  = 2'h3;
   // Tick periods in system clocks
   localparam logic [15:0] TICK_DIV12 = 16'h000C;
   localparam logic [15:0] TICK_DIV4  = 16'h0004;
   localparam logic [15:0] TICK_DIV1  = 16'h0001;
   // Power management divider codes and extra shifts
   localparam logic [1:0] PMD_SLOW  = 2'h2;
   localparam logic [1:0] PMD_SLOWEST = 2'h3;
   localparam int PMD_SHIFT_SLOW    = 2;
   localparam int PMD_SHIFT_SLOWEST = 10;
   // Edge pattern on four samples, oldest first
   localparam logic [3:0] EDGE_PATTERN = 4'hC;
   localparam logic [7:0] RESET_BYTE   = 8'h00;
   // One timer nibble of the mode register
   typedef struct packed {
      logic       gate;
      logic       count_sel;
      logic [1:0] mode;
   } dtc_ctl_t;
   // Result of one count step
   typedef struct packed {
      logic       ovf;
      logic [7:0] high;
      logic [7:0] low;
   } dtc_step_t;
endpackage
`default_nettype wire

// ### hw/dtc_top.sv
/*
 * Dual timer/counter with APB register access.
 * Assumes pins synchronous to pclk and a master keeping APB signalling.
 */
// Design decision made here: the APB slave port.
`default_nettype none
module dtc_top (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [dtc_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   output var  logic [31:0]                prdata,
   output var  logic                       pready,
   output var  logic                       pslverr,
   input  wire logic                       timer_a_count_pin,
   input  wire logic                       timer_b_count_pin,
   input  wire logic                       timer_a_gate_pin,
   input  wire logic                       timer_b_gate_pin,
   input  wire logic                       timer_a_irq_ack,
   input  wire logic                       timer_b_irq_ack,
   output var  logic                       timer_a_overflow_flag,
   output var  logic                       timer_b_overflow_flag
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [7:0]  timer_control_flags_reg;
   logic [7:0]  timer_mode_select_reg;
   logic [7:0]  timer_a_count_low_reg;
   logic [7:0]  timer_a_count_high_reg;
   logic [7:0]  timer_b_count_low_reg;
   logic [7:0]  timer_b_count_high_reg;
   logic [7:0]  clock_prescale_control_reg;
   logic [7:0]  clock_highspeed_select_reg;
   logic [1:0]  power_management_divider_reg;
   logic [15:0] presc_a_reg;
   logic [15:0] presc_b_reg;
   logic [3:0]  hist_a_reg;
   logic [3:0]  hist_b_reg;
   logic        pready_reg;
   logic [31:0] prdata_reg;
   logic        pslverr_reg;
   logic        access;
   logic        wr;
   logic [7:0]  idx;
   logic        mapped;
   logic [7:0]  rd_byte;
   dtc_pkg::dtc_ctl_t  ctl_a;
   dtc_pkg::dtc_ctl_t  ctl_b;
   dtc_pkg::dtc_step_t step_a;
   dtc_pkg::dtc_step_t step_b;
   logic        split_a;
   logic        tick_a;
   logic        tick_b;
   logic        edge_a;
   logic        edge_b;
   logic        run_a;
   logic        run_b;
   logic        inc_a;
   logic        inc_b;
   logic        inc_ah;
   logic        set_a;
   logic        set_b;
   logic        clr_a;
   logic        clr_b;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic dtc_pkg::dtc_step_t count_step(
      input logic [1:0] mode,
      input logic [7:0] lo,
      input logic [7:0] hi);
      dtc_pkg::dtc_step_t r;
      logic [12:0] v13;
      logic [15:0] v16;
      r = '0;
      v13 = {hi, lo[4:0]};
      v16 = {hi, lo};
      unique case (mode)
         dtc_pkg::MODE_13BIT: begin
            v13 = v13 + 13'h0001;
            r.ovf = (v13 == 13'h0000);
            r.high = v13[12:5];
            r.low = {lo[7:5], v13[4:0]};
         end
         dtc_pkg::MODE_16BIT: begin
            v16 = v16 + 16'h0001;
            r.ovf = (v16 == 16'h0000);
            r.high = v16[15:8];
            r.low = v16[7:0];
         end
         dtc_pkg::MODE_RELOAD: begin
            r.ovf = (lo == 8'hFF);
            r.high = hi;
            r.low = r.ovf ? hi : lo + 8'h01;
         end
         dtc_pkg::MODE_SPLIT: begin
            r.ovf = (lo == 8'hFF);
            r.high = hi;
            r.low = lo + 8'h01;
         end
      endcase
      return r;
   endfunction

   function automatic logic [15:0] tick_period(
      input logic       div1,
      input logic       div4,
      input logic [1:0] pmd);
      logic [15:0] p;
      p = div1 ? dtc_pkg::TICK_DIV1 :
          div4 ? dtc_pkg::TICK_DIV4 : dtc_pkg::TICK_DIV12;
      if (pmd == dtc_pkg::PMD_SLOW) begin
         p = p << dtc_pkg::PMD_SHIFT_SLOW;
      end else if (pmd == dtc_pkg::PMD_SLOWEST) begin
         p = p << dtc_pkg::PMD_SHIFT_SLOWEST;
      end
      return p;
   endfunction

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   assign idx = paddr[dtc_pkg::ADDR_W-3:2];
   assign access = psel & penable & pready_reg;
   assign wr = access & pwrite & mapped;
   always_comb begin
      mapped = (paddr[1:0] == 2'h0) &&
               (paddr[dtc_pkg::ADDR_W-1 -: 2] == 2'h0);
      unique case (idx)
         dtc_pkg::IDX_CTRL:     rd_byte = {timer_control_flags_reg[7:4],
                                           4'h0};
         dtc_pkg::IDX_MODE:     rd_byte = timer_mode_select_reg;
         dtc_pkg::IDX_A_LOW:    rd_byte = timer_a_count_low_reg;
         dtc_pkg::IDX_B_LOW:    rd_byte = timer_b_count_low_reg;
         dtc_pkg::IDX_A_HIGH:   rd_byte = timer_a_count_high_reg;
         dtc_pkg::IDX_B_HIGH:   rd_byte = timer_b_count_high_reg;
         dtc_pkg::IDX_PRESCALE: rd_byte = clock_prescale_control_reg;
         dtc_pkg::IDX_HISPEED:  rd_byte = clock_highspeed_select_reg;
         dtc_pkg::IDX_PMDIV:    rd_byte = {power_management_divider_reg,
                                           6'h00};
         default: begin
            rd_byte = 8'h00;
            mapped = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= psel & penable & ~pready_reg;
         if (psel & penable & ~pready_reg) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pslverr_reg <= ~mapped;
         end else begin
            pslverr_reg <= 1'b0;
         end
      end
   end
   assign pready = pready_reg;
   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_mode_select_reg <= dtc_pkg::RESET_BYTE;
         clock_prescale_control_reg <= dtc_pkg::RESET_BYTE;
         clock_highspeed_select_reg <= dtc_pkg::RESET_BYTE;
         power_management_divider_reg <= 2'h0;
      end else if (wr) begin
         if (idx == dtc_pkg::IDX_MODE) begin
            timer_mode_select_reg <= pwdata[7:0];
         end
         if (idx == dtc_pkg::IDX_PRESCALE) begin
            clock_prescale_control_reg <= pwdata[7:0];
         end
         if (idx == dtc_pkg::IDX_HISPEED) begin
            clock_highspeed_select_reg <= pwdata[7:0];
         end
         if (idx == dtc_pkg::IDX_PMDIV) begin
            power_management_divider_reg <= pwdata[7:6];
         end
      end
   end

   assign ctl_a = timer_mode_select_reg[dtc_pkg::NIB_A_LSB +: 4];
   assign ctl_b = timer_mode_select_reg[dtc_pkg::NIB_B_LSB +: 4];
   assign split_a = (ctl_a.mode == dtc_pkg::MODE_SPLIT);

   // ----------------------------------------------------------------
   // Tick prescalers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_a_reg <= 16'h0000;
         presc_b_reg <= 16'h0000;
      end else begin
         presc_a_reg <= tick_a ? tick_period(
            clock_highspeed_select_reg[dtc_pkg::BIT_A_SEL],
            clock_prescale_control_reg[dtc_pkg::BIT_A_SEL],
            power_management_divider_reg) - 16'h0001
            : presc_a_reg - 16'h0001;
         presc_b_reg <= tick_b ? tick_period(
            clock_highspeed_select_reg[dtc_pkg::BIT_B_SEL],
            clock_prescale_control_reg[dtc_pkg::BIT_B_SEL],
            power_management_divider_reg) - 16'h0001
            : presc_b_reg - 16'h0001;
      end
   end
   assign tick_a = (presc_a_reg == 16'h0000);
   assign tick_b = (presc_b_reg == 16'h0000);

   // ----------------------------------------------------------------
   // Count pin edge detection
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hist_a_reg <= 4'h0;
         hist_b_reg <= 4'h0;
      end else begin
         hist_a_reg <= {hist_a_reg[2:0], timer_a_count_pin};
         hist_b_reg <= {hist_b_reg[2:0], timer_b_count_pin};
      end
   end
   assign edge_a = (hist_a_reg == dtc_pkg::EDGE_PATTERN);
   assign edge_b = (hist_b_reg == dtc_pkg::EDGE_PATTERN);

   // ----------------------------------------------------------------
   // Count enables
   // ----------------------------------------------------------------
   assign run_a = timer_control_flags_reg[dtc_pkg::BIT_A_RUN] &
                  (~ctl_a.gate | timer_a_gate_pin);
   assign run_b = timer_control_flags_reg[dtc_pkg::BIT_B_RUN] &
                  (~ctl_b.gate | timer_b_gate_pin);
   assign inc_a = run_a & (ctl_a.count_sel ? edge_a : tick_a);
   assign inc_ah = split_a & tick_a &
                   timer_control_flags_reg[dtc_pkg::BIT_B_RUN];
   always_comb begin
      if (ctl_b.mode == dtc_pkg::MODE_SPLIT) begin
         inc_b = 1'b0;
      end else if (split_a) begin
         inc_b = tick_b;
      end else begin
         inc_b = run_b & (ctl_b.count_sel ? edge_b : tick_b);
      end
   end
   assign step_a = count_step(ctl_a.mode, timer_a_count_low_reg,
                              timer_a_count_high_reg);
   assign step_b = count_step(ctl_b.mode, timer_b_count_low_reg,
                              timer_b_count_high_reg);

   // ----------------------------------------------------------------
   // Count registers, software write wins over a count
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_a_count_low_reg <= dtc_pkg::RESET_BYTE;
         timer_a_count_high_reg <= dtc_pkg::RESET_BYTE;
      end else begin
         if (wr && idx == dtc_pkg::IDX_A_LOW) begin
            timer_a_count_low_reg <= pwdata[7:0];
         end else if (inc_a) begin
            timer_a_count_low_reg <= step_a.low;
         end
         if (wr && idx == dtc_pkg::IDX_A_HIGH) begin
            timer_a_count_high_reg <= pwdata[7:0];
         end else if (inc_ah) begin
            timer_a_count_high_reg <= timer_a_count_high_reg + 8'h01;
         end else if (inc_a && !split_a) begin
            timer_a_count_high_reg <= step_a.high;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_b_count_low_reg <= dtc_pkg::RESET_BYTE;
         timer_b_count_high_reg <= dtc_pkg::RESET_BYTE;
      end else begin
         if (wr && idx == dtc_pkg::IDX_B_LOW) begin
            timer_b_count_low_reg <= pwdata[7:0];
         end else if (inc_b) begin
            timer_b_count_low_reg <= step_b.low;
         end
         if (wr && idx == dtc_pkg::IDX_B_HIGH) begin
            timer_b_count_high_reg <= pwdata[7:0];
         end else if (inc_b) begin
            timer_b_count_high_reg <= step_b.high;
         end
      end
   end

   // ----------------------------------------------------------------
   // Control flags, hardware set wins over clear
   // ----------------------------------------------------------------
   assign set_a = inc_a & step_a.ovf;
   assign set_b = (inc_ah & (timer_a_count_high_reg == 8'hFF)) |
                  (~split_a & inc_b & step_b.ovf);
   assign clr_a = timer_a_irq_ack |
                  (wr & idx == dtc_pkg::IDX_CTRL &
                   ~pwdata[dtc_pkg::BIT_A_FLAG]);
   assign clr_b = timer_b_irq_ack |
                  (wr & idx == dtc_pkg::IDX_CTRL &
                   ~pwdata[dtc_pkg::BIT_B_FLAG]);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_control_flags_reg <= dtc_pkg::RESET_BYTE;
      end else begin
         if (wr && idx == dtc_pkg::IDX_CTRL) begin
            timer_control_flags_reg[dtc_pkg::BIT_A_RUN] <=
               pwdata[dtc_pkg::BIT_A_RUN];
            timer_control_flags_reg[dtc_pkg::BIT_B_RUN] <=
               pwdata[dtc_pkg::BIT_B_RUN];
         end
         if (set_a) begin
            timer_control_flags_reg[dtc_pkg::BIT_A_FLAG] <= 1'b1;
         end else if (clr_a) begin
            timer_control_flags_reg[dtc_pkg::BIT_A_FLAG] <= 1'b0;
         end
         if (set_b) begin
            timer_control_flags_reg[dtc_pkg::BIT_B_FLAG] <= 1'b1;
         end else if (clr_b) begin
            timer_control_flags_reg[dtc_pkg::BIT_B_FLAG] <= 1'b0;
         end
      end
   end
   assign timer_a_overflow_flag =
      timer_control_flags_reg[dtc_pkg::BIT_A_FLAG];
   assign timer_b_overflow_flag =
      timer_control_flags_reg[dtc_pkg::BIT_B_FLAG];

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_split_top_wrap;
      inc_ah && timer_a_count_high_reg == 8'hFF && !wr;
   endsequence
   sequence s_flag_b_up;
      timer_b_overflow_flag && timer_a_count_high_reg == 8'h00;
   endsequence

   AST_MODE0_WRAP: assert property (
      inc_a && !wr && ctl_a.mode == dtc_pkg::MODE_13BIT &&
      {timer_a_count_high_reg, timer_a_count_low_reg[4:0]} == 13'h1FFF
      |=> timer_a_overflow_flag && timer_a_count_high_reg == 8'h00 &&
          timer_a_count_low_reg[4:0] == 5'h00)
      else $error("13-bit wrap missed");
   AST_MODE1_WRAP: assert property (
      inc_a && !wr && ctl_a.mode == dtc_pkg::MODE_16BIT &&
      {timer_a_count_high_reg, timer_a_count_low_reg} == 16'hFFFF
      |=> timer_a_overflow_flag &&
          {timer_a_count_high_reg, timer_a_count_low_reg} == 16'h0000)
      else $error("16-bit rollover missed");
   AST_MODE2_RELOAD: assert property (
      inc_b && !wr && ctl_b.mode == dtc_pkg::MODE_RELOAD &&
      timer_b_count_low_reg == 8'hFF
      |=> timer_b_count_low_reg == $past(timer_b_count_high_reg))
      else $error("reload not taken");
   AST_RELOAD_HIGH_KEPT: assert property (
      ctl_b.mode == dtc_pkg::MODE_RELOAD && !wr
      |=> $stable(timer_b_count_high_reg))
      else $error("reload byte altered");
   AST_STOP_HOLDS: assert property (
      !run_a && !split_a && !wr
      |=> $stable(timer_a_count_low_reg) && $stable(timer_a_count_high_reg))
      else $error("stopped timer moved");
   AST_EDGE_PATTERN: assert property (
      edge_a |-> $past(timer_a_count_pin, 4) && $past(timer_a_count_pin, 3)
                 && !$past(timer_a_count_pin, 2) && !$past(timer_a_count_pin))
      else $error("edge without two high and two low samples");
   AST_SPLIT_TOP: assert property (
      s_split_top_wrap |=> s_flag_b_up)
      else $error("split high byte overflow not flagged");
   AST_B_SPLIT_HOLD: assert property (
      ctl_b.mode == dtc_pkg::MODE_SPLIT && !wr
      |=> $stable(timer_b_count_low_reg) && $stable(timer_b_count_high_reg))
      else $error("timer b moved in split mode");
   AST_B_NO_FLAG: assert property (
      split_a && !timer_control_flags_reg[dtc_pkg::BIT_B_RUN]
      |=> !$rose(timer_b_overflow_flag))
      else $error("timer b flagged while a split");
   AST_SET_WINS: assert property (
      set_a && clr_a |=> timer_a_overflow_flag)
      else $error("flag clear beat set");
   AST_FAST_TICK: assert property (
      clock_highspeed_select_reg[dtc_pkg::BIT_A_SEL] &&
      power_management_divider_reg == 2'h0 && tick_a
      ##1 $stable(clock_highspeed_select_reg) |-> tick_a)
      else $error("div-by-1 tick missing");
endmodule
`default_nettype wire
